// [core/pgm_defs.vh]
`ifndef PGM_DEFS_VH
`define PGM_DEFS_VH
`define PGM_ADDR_DIRECTION   16'hfeb1
`define PGM_ADDR_PIN_STATE   16'hff51
`define PGM_ADDR_OUT_LATCH   16'hff61
`define PGM_RST_DIRECTION    8'h00
`define PGM_RST_OUT_LATCH    8'h00
`define PGM_UNDEF_READ       8'hff
`define PGM_CCLR_PWM2_B      2'h2
`define PGM_CCLR_PWM2_A      2'h1
`define PGM_MODE_NORMAL      4'h0
`define PGM_MODE_PWM2        4'h3
`define PGM_TMR_CLR_RESET    2'h3
`endif

// [core/pgm_timer_pin.v]
`timescale 1ns/1ps
`default_nettype none
// Output decision of one multi-function timer pin
module pgm_timer_pin (
   input  wire [3:0] mode,
   input  wire [3:0] io_ctl,
   input  wire [1:0] cclr,
   input  wire [1:0] cclr_self,
   output wire       drive
);
`include "pgm_defs.vh"
   wire normal_mode;
   wire cmp_out;
   wire pwm2_out;
   assign normal_mode = (mode == `PGM_MODE_NORMAL) || (mode[3:2] == 2'h1);
   assign cmp_out  = normal_mode && !io_ctl[3] && (io_ctl[1:0] != 2'h0);
   assign pwm2_out = (mode == `PGM_MODE_PWM2) && (io_ctl[1:0] != 2'h0)
                     && (cclr != cclr_self);
   assign drive = cmp_out || pwm2_out;
endmodule
`default_nettype wire

// [core/pgm_port.v]
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pgm_port #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             rst_b,
   input  wire             hw_standby,
   input  wire             sw_standby,
   input  wire [15:0]      addr,
   input  wire [7:0]       wdata,
   input  wire             wr,
   input  wire             rd,
   output reg  [7:0]       rdata,
   input  wire [WIDTH-1:0] pin_in,
   output reg  [WIDTH-1:0] pin_out,
   output reg  [WIDTH-1:0] pin_oe,
   input  wire [7:0]       pattern_out,
   input  wire [7:0]       next_data_enable_low,
   input  wire [3:0]       ch5_mode,
   input  wire [3:0]       ch5_a_io,
   input  wire [3:0]       ch5_b_io,
   input  wire [1:0]       ch5_cclr,
   input  wire [3:0]       ch4_mode,
   input  wire [3:0]       ch4_a_io,
   input  wire [3:0]       ch4_b_io,
   input  wire [1:0]       ch4_cclr,
   input  wire             timer5_a_out,
   input  wire             timer5_b_out,
   input  wire             timer4_a_out,
   input  wire             timer4_b_out,
   input  wire [3:0]       tmr0_output_select,
   input  wire [3:0]       tmr1_output_select,
   input  wire             tmr0_compare_out,
   input  wire             tmr1_compare_out,
   input  wire [2:0]       tmr1_clock_select,
   input  wire [1:0]       tmr1_counter_clear,
   output reg              timer5_b_capture,
   output reg              timer5_a_capture,
   output reg              timer4_b_capture,
   output reg              timer4_a_capture,
   output reg              tmr1_ext_clock_in,
   output reg              tmr1_reset_in,
   output reg  [WIDTH-1:0] port_in_level
);
`include "pgm_defs.vh"
   reg  [7:0] dir_q;
   reg  [7:0] latch_q;
   reg  [7:0] state_q;
   reg  [7:0] out_d;
   reg  [7:0] oe_d;
   wire [7:0] view;
   wire       drv5b;
   wire       drv5a;
   wire       drv4b;
   wire       drv4a;
   wire       hold;
   wire       cap_mode5;
   wire       cap_mode4;
   integer    i;

   assign hold = sw_standby && !hw_standby;
   assign view = (dir_q & latch_q) | (~dir_q & pin_in[7:0]);
   assign cap_mode5 = (ch5_mode == `PGM_MODE_NORMAL) || (ch5_mode[3:2] == 2'h1);
   assign cap_mode4 = (ch4_mode == `PGM_MODE_NORMAL) || (ch4_mode[3:2] == 2'h1);

   pgm_timer_pin u_p7 (
      .mode      (ch5_mode),
      .io_ctl    (ch5_b_io),
      .cclr      (ch5_cclr),
      .cclr_self (`PGM_CCLR_PWM2_B),
      .drive     (drv5b)
   );
   pgm_timer_pin u_p6 (
      .mode      (ch5_mode),
      .io_ctl    (ch5_a_io),
      .cclr      (ch5_cclr),
      .cclr_self (`PGM_CCLR_PWM2_A),
      .drive     (drv5a)
   );
   pgm_timer_pin u_p5 (
      .mode      (ch4_mode),
      .io_ctl    (ch4_b_io),
      .cclr      (ch4_cclr),
      .cclr_self (`PGM_CCLR_PWM2_B),
      .drive     (drv4b)
   );
   pgm_timer_pin u_p4 (
      .mode      (ch4_mode),
      .io_ctl    (ch4_a_io),
      .cclr      (ch4_cclr),
      .cclr_self (`PGM_CCLR_PWM2_A),
      .drive     (drv4a)
   );

   // Pin multiplexing; no chip mode input takes part
   always @* begin
      for (i = 0; i < 8; i = i + 1) begin
         oe_d[i]  = dir_q[i];
         out_d[i] = next_data_enable_low[i] ? pattern_out[i] : latch_q[i];
      end
      if (drv4a) begin
         oe_d[4]  = 1'b1;
         out_d[4] = timer4_a_out;
      end
      if (drv4b) begin
         oe_d[5]  = 1'b1;
         out_d[5] = timer4_b_out;
      end
      if (drv5a) begin
         oe_d[6]  = 1'b1;
         out_d[6] = timer5_a_out;
      end
      if (drv5b) begin
         oe_d[7]  = 1'b1;
         out_d[7] = timer5_b_out;
      end
      if (tmr0_output_select != 4'h0) begin
         oe_d[6]  = 1'b1;
         out_d[6] = tmr0_compare_out;
      end
      if (tmr1_output_select != 4'h0) begin
         oe_d[7]  = 1'b1;
         out_d[7] = tmr1_compare_out;
      end
   end

   always @(posedge clk) begin
      if (!rst_b || hw_standby) begin
         dir_q   <= `PGM_RST_DIRECTION;
         latch_q <= `PGM_RST_OUT_LATCH;
      end else if (wr && !hold) begin
         if (addr == `PGM_ADDR_DIRECTION)
            dir_q <= wdata;
         if (addr == `PGM_ADDR_OUT_LATCH)
            latch_q <= wdata;
      end
   end

   // Pin-state view tracks pins except while in software standby without hardware standby
   always @(posedge clk) begin
      if (!rst_b) begin
         state_q <= 8'h00;
      end else if (!hold) begin
         state_q <= view;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `PGM_ADDR_DIRECTION: rdata <= `PGM_UNDEF_READ;
            `PGM_ADDR_OUT_LATCH: rdata <= latch_q;
            `PGM_ADDR_PIN_STATE: rdata <= hold ? state_q : view;
            default:             rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         pin_out           <= {WIDTH{1'b0}};
         pin_oe            <= {WIDTH{1'b0}};
         port_in_level     <= {WIDTH{1'b0}};
         timer5_b_capture  <= 1'b0;
         timer5_a_capture  <= 1'b0;
         timer4_b_capture  <= 1'b0;
         timer4_a_capture  <= 1'b0;
         tmr1_ext_clock_in <= 1'b0;
         tmr1_reset_in     <= 1'b0;
      end else begin
         pin_out          <= out_d;
         pin_oe           <= oe_d;
         port_in_level    <= pin_in;
         timer5_b_capture <= cap_mode5 && ch5_b_io[3] && pin_in[7];
         timer5_a_capture <= cap_mode5 && ch5_a_io[3] && pin_in[6];
         timer4_b_capture <= cap_mode4 && (ch4_b_io[3:2] == 2'h2)
                             && pin_in[5];
         timer4_a_capture <= cap_mode4 && (ch4_a_io[3:2] == 2'h2)
                             && pin_in[4];
         tmr1_ext_clock_in <= tmr1_clock_select[2] && pin_in[5];
         tmr1_reset_in    <= (tmr1_counter_clear == `PGM_TMR_CLR_RESET)
                             && pin_in[4];
      end
   end
endmodule
`default_nettype wire

// [verification/pgm_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pgm_port_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [15:0] addr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic [7:0]  pin_in,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe,
   input wire logic [3:0]  ch5_mode,
   input wire logic [3:0]  ch5_b_io,
   input wire logic [3:0]  ch4_b_io,
   input wire logic        timer5_b_out,
   input wire logic [3:0]  tmr1_output_select,
   input wire logic        tmr1_compare_out,
   input wire logic [2:0]  tmr1_clock_select,
   input wire logic [1:0]  tmr1_counter_clear,
   input wire logic        timer5_b_capture,
   input wire logic        timer4_b_capture,
   input wire logic        tmr1_ext_clock_in,
   input wire logic        tmr1_reset_in
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_dir_read_ones: assert property (rd && addr == 16'hfeb1 |=> rdata == 8'hff)
      else $error("direction read not all ones");
   chk_reset_in_on: assert property (tmr1_counter_clear == 2'h3 && !pin_oe[4]
      |=> tmr1_reset_in == $past(pin_in[4])) else $error("reset input not fed");
   chk_reset_in_off: assert property (tmr1_counter_clear != 2'h3 |=> !tmr1_reset_in)
      else $error("reset input fed while off");
   chk_ext_clock_on: assert property (tmr1_clock_select[2] && !pin_oe[5]
      |=> tmr1_ext_clock_in == $past(pin_in[5])) else $error("clock input not fed");
   chk_tmr_pin_wins: assert property (tmr1_output_select != 4'h0
      |=> pin_oe[7] && pin_out[7] == $past(tmr1_compare_out)) else $error("pin 7 not timer");
   chk_cmp_drives_pin: assert property (
      ch5_mode == 4'h0 && !ch5_b_io[3] && ch5_b_io[1:0] != 2'h0 && tmr1_output_select == 4'h0
      |=> pin_oe[7] && pin_out[7] == $past(timer5_b_out))
      else $error("pin 7 not compare output");
   chk_cap5_on: assert property (ch5_mode == 4'h0 && ch5_b_io[3]
      |=> timer5_b_capture == $past(pin_in[7])) else $error("capture 5 not fed");
   chk_cap5_off: assert property (!ch5_b_io[3] |=> !timer5_b_capture)
      else $error("capture 5 fed while off");
   chk_cap4_off: assert property (ch4_b_io[3:2] != 2'h2 |=> !timer4_b_capture)
      else $error("capture 4 fed while off");
endmodule
bind pgm_port pgm_port_chk u_chk (.clk, .rst_b, .addr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
   .ch5_mode, .ch5_b_io, .ch4_b_io, .timer5_b_out, .tmr1_output_select, .tmr1_compare_out,
   .tmr1_clock_select, .tmr1_counter_clear, .timer5_b_capture, .timer4_b_capture,
   .tmr1_ext_clock_in, .tmr1_reset_in);
`default_nettype wire

// [verification/pgm_board.sv]
`timescale 1ns/1ps
`default_nettype none
// Board side: a driven pin shows the port value, any other pin the board level
module pgm_board (
   input wire logic  [7:0] pin_out,
   input wire logic  [7:0] pin_oe,
   input wire logic  [7:0] drive,
   output var logic  [7:0] pin_in
);
   always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule
`default_nettype wire

// [verification/port_two_gpio_pin_mux_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module port_two_gpio_pin_mux_bench;
   logic clk = 0, rst_b = 0, hw_standby = 0, sw_standby = 0, wr = 0, rd = 0, timer5_a_out = 0;
   logic timer4_a_out = 0, timer4_b_out = 0, timer5_b_out = 0, tmr0_compare_out = 0;
   logic tmr1_compare_out = 0;
   logic [3:0] ch5_mode = 4'h0, ch5_b_io = 4'h0, ch4_b_io = 4'h0, tmr0_output_select = 4'h0;
   logic [3:0] tmr1_output_select = 4'h0;
   logic [7:0] wdata = 8'h0, pattern_out = 8'h0, next_data_enable_low = 8'h0, board = 8'h3c;
   logic [7:0] rdata, pin_in, pin_out, pin_oe;
   logic [15:0] addr = 16'h0;
   logic [2:0] tmr1_clock_select = 3'h4;
   logic [1:0] tmr1_counter_clear = 2'h3;
   int errors = 0, num_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   pgm_port DUT (.clk, .rst_b, .hw_standby, .sw_standby, .addr, .wdata, .wr, .rd, .rdata,
      .pin_in, .pin_out, .pin_oe, .pattern_out, .next_data_enable_low, .ch5_mode,
      .ch5_a_io(4'h0), .ch5_b_io, .ch5_cclr(2'h0), .ch4_mode(4'h0), .ch4_a_io(4'h0), .ch4_b_io,
      .ch4_cclr(2'h0), .timer5_a_out, .timer5_b_out, .timer4_a_out, .timer4_b_out,
      .tmr0_output_select, .tmr1_output_select, .tmr0_compare_out, .tmr1_compare_out,
      .tmr1_clock_select, .tmr1_counter_clear, .timer5_b_capture(), .timer5_a_capture(),
      .timer4_b_capture(), .timer4_a_capture(), .tmr1_ext_clock_in(), .tmr1_reset_in(),
      .port_in_level());
   pgm_board u_board (.pin_out, .pin_oe, .drive(board), .pin_in);
   task check(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [15:0] a, input logic [7:0] want);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, want);
   endtask
   task pins(input logic [7:0] want);
      repeat (2) @(posedge clk);
      #1 check(pin_out & 8'hc0, want);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         give_verdict;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rreg(16'hff61, 8'h00);
      rreg(16'hfeb1, 8'hff);
      rreg(16'hff51, 8'h3c);
      $display("test reset done");
      wreg(16'hfeb1, 8'hc0);
      wreg(16'hff61, 8'ha5);
      wreg(16'hff51, 8'h00);
      rreg(16'hff51, 8'hbc);
      check(pin_oe, 8'hc0);
      pins(8'h80);
      $display("test access done");
      sw_standby <= 1'b1;
      board <= 8'h30;
      wreg(16'hff61, 8'h5a);
      rreg(16'hff51, 8'hbc);
      rreg(16'hff61, 8'ha5);
      sw_standby <= 1'b0;
      rreg(16'hff51, 8'hb0);
      hw_standby <= 1'b1;
      @(posedge clk);
      hw_standby <= 1'b0;
      rreg(16'hff61, 8'h00);
      check(pin_oe, 8'h00);
      $display("test standby done");
      wreg(16'hfeb1, 8'hc0);
      wreg(16'hff61, 8'hc0);
      next_data_enable_low <= 8'h80;
      pins(8'h40);
      ch5_b_io <= 4'h1;
      timer5_b_out <= 1'b1;
      pins(8'hc0);
      tmr1_output_select <= 4'h1;
      tmr1_counter_clear <= 2'h0;
      pins(8'h40);
      ch5_b_io <= 4'h8;
      tmr1_output_select <= 4'h0;
      board <= 8'hb0;
      wreg(16'hfeb1, 8'h00);
      rreg(16'hff51, 8'hb0);
      $display("test mux done");
      give_verdict;
   end
endmodule
`default_nettype wire
